// >>> verilog/gpch_pkg.sv
// Purpose: Shared constants of the graphics function configuration header
// Assumes: Byte-addressed configuration space, 32-bit dword accesses
// Notes:   Dword indices are byte offset divided by four
package gpch_pkg;

  localparam int unsigned CFG_AW  = 8;
  localparam int unsigned CFG_DWW = 6;

  // Printed byte offsets of the header registers
  localparam logic [CFG_AW-1:0] OFS_HEADER_LAYOUT   = 8'h0e;
  localparam logic [CFG_AW-1:0] OFS_SELF_TEST       = 8'h0f;
  localparam logic [CFG_AW-1:0] OFS_APERTURE_BASE   = 8'h10;
  localparam logic [CFG_AW-1:0] OFS_WINDOW_BASE     = 8'h14;
  localparam logic [CFG_AW-1:0] OFS_SUBSYS_VENDOR   = 8'h2c;
  localparam logic [CFG_AW-1:0] OFS_SUBSYS_IDENT    = 8'h2e;
  localparam logic [CFG_AW-1:0] OFS_OPTION_ROM      = 8'h30;
  localparam logic [CFG_AW-1:0] OFS_CAP_POINTER     = 8'h34;
  localparam logic [CFG_AW-1:0] OFS_IRQ_LINE        = 8'h3c;
  localparam logic [CFG_AW-1:0] OFS_IRQ_PIN         = 8'h3d;
  localparam logic [CFG_AW-1:0] OFS_MIN_GRANT       = 8'h3e;
  localparam logic [CFG_AW-1:0] OFS_MAX_LATENCY     = 8'h3f;

  // Dword indices that hold them
  localparam logic [CFG_DWW-1:0] DW_HEADER   = OFS_HEADER_LAYOUT[7:2];
  localparam logic [CFG_DWW-1:0] DW_APERTURE = OFS_APERTURE_BASE[7:2];
  localparam logic [CFG_DWW-1:0] DW_WINDOW   = OFS_WINDOW_BASE[7:2];
  localparam logic [CFG_DWW-1:0] DW_SUBSYS   = OFS_SUBSYS_VENDOR[7:2];
  localparam logic [CFG_DWW-1:0] DW_ROM      = OFS_OPTION_ROM[7:2];
  localparam logic [CFG_DWW-1:0] DW_CAP      = OFS_CAP_POINTER[7:2];
  localparam logic [CFG_DWW-1:0] DW_IRQ      = OFS_IRQ_LINE[7:2];

  // Fixed read values
  localparam logic [7:0]  HEADER_LAYOUT_VAL = 8'h00;
  localparam logic [7:0]  SELF_TEST_VAL     = 8'h00;
  localparam logic [31:0] OPTION_ROM_VAL    = 32'h0000_0000;
  localparam logic [7:0]  CAP_POINTER_VAL   = 8'hdc;
  localparam logic [7:0]  IRQ_PIN_VAL       = 8'h01;
  localparam logic [7:0]  MIN_GRANT_VAL     = 8'h00;
  localparam logic [7:0]  MAX_LATENCY_VAL   = 8'h00;

  // Reset values of writable state
  localparam logic [7:0]  IRQ_LINE_RST   = 8'h00;
  localparam logic [15:0] SUBSYS_RST     = 16'h0000;
  localparam logic [31:0] APERTURE_RST   = 32'h0000_0008;
  localparam logic [31:0] WINDOW_RST     = 32'h0000_0000;

  // Base register field positions and subsystem id count
  localparam int unsigned APER_BASE_LSB  = 26;
  localparam int unsigned APER_SEL_BIT   = 25;
  localparam int unsigned WIN_BASE_LSB   = 19;
  localparam int unsigned PREFETCH_BIT   = 3;
  localparam int unsigned SUBSYS_COUNT   = 2;

endpackage

// >>> verilog/gpch_wonce_if.sv
// Purpose: Carrier between the header and one write-once identifier
// Assumes: Single clock domain
// Notes:   Write strobe is a one-cycle pulse
`timescale 1ns/1ps
interface gpch_wonce_if;
  logic        wr;
  logic [1:0]  be;
  logic [15:0] wdata;
  logic [15:0] value;
  logic        locked;

  modport ctrl  (output wr, output be, output wdata, input value, input locked);
  modport store (input wr, input be, input wdata, output value, output locked);
endinterface

// >>> verilog/gpch_write_once.sv
// Purpose: 16-bit identifier that takes one write and then locks
// Assumes: Synchronous active-low reset clears value and lock
// Notes:   The first write locks even if it enables only one byte
`timescale 1ns/1ps
module gpch_write_once (
  input  wire logic       clock_i,
  input  wire logic       nrst_i,
  gpch_wonce_if.store     port
);
  import gpch_pkg::*;

  logic [15:0] value;
  logic        locked;

  // Lock on first write; only reset reopens it
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      locked <= 1'b0;
    end else if (port.wr) begin
      locked <= 1'b1;
    end
  end

  for (genvar b = 0; b < 2; b++) begin : g_lane
    always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
        value[8*b +: 8] <= SUBSYS_RST[8*b +: 8];
      end else if (port.wr && !locked && port.be[b]) begin
        value[8*b +: 8] <= port.wdata[8*b +: 8];
      end
    end
  end

  assign port.value  = value;
  assign port.locked = locked;
endmodule

// >>> verilog/gpch_config_header.sv
// Purpose: Configuration header, offsets 0eh to 3fh, of a graphics function
// Assumes: Dword config accesses with byte enables; size select from same clock
// Notes:   One access per request, answered one cycle later
`timescale 1ns/1ps
module gpch_config_header (
  input  wire logic                            clock_i,
  input  wire logic                            nrst_i,
  input  wire logic                            size_select_i,
  input  wire logic                            cfg_req_i,
  input  wire logic                            cfg_wr_i,
  input  wire logic [gpch_pkg::CFG_AW-1:0]     cfg_addr_i,
  input  wire logic [3:0]                      cfg_be_i,
  input  wire logic [31:0]                     cfg_wdata_i,
  input  wire logic [31:0]                     mem_addr_i,
  output logic                                 cfg_ack_o,
  output logic [31:0]                          cfg_rdata_o,
  output logic [31:0]                          aperture_base_o,
  output logic                                 aperture_64mb_o,
  output logic [31:0]                          window_base_o,
  output logic [7:0]                           irq_routing_line_o,
  output logic [1:0]                           subsys_locked_o,
  output logic                                 aperture_hit_o,
  output logic                                 window_hit_o
);
  import gpch_pkg::*;

  logic [CFG_DWW-1:0] dword;
  logic               wr_take;
  logic               rd_take;

  logic [31:APER_SEL_BIT]  aper_hi;
  logic [31:WIN_BASE_LSB]  win_hi;
  logic [7:0]              irq_routing_line;

  logic [31:0] aperture_word;
  logic [31:0] window_word;
  logic [31:0] next_rdata;

  logic [15:0] subsys_value [SUBSYS_COUNT];
  logic        subsys_lock  [SUBSYS_COUNT];

  assign dword   = cfg_addr_i[CFG_AW-1:2];
  assign wr_take = cfg_req_i && cfg_wr_i;
  assign rd_take = cfg_req_i && !cfg_wr_i;

  // Aperture base high bits
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      aper_hi <= APERTURE_RST[31:APER_SEL_BIT];
    end else begin
      if (wr_take && dword == DW_APERTURE && cfg_be_i[3]) begin
        aper_hi[31:APER_BASE_LSB] <= cfg_wdata_i[31:APER_BASE_LSB];
      end
      // Bit drops to zero whenever the 64 MB size is chosen
      if (!size_select_i) begin
        aper_hi[APER_SEL_BIT] <= 1'b0;
      end else if (wr_take && dword == DW_APERTURE && cfg_be_i[3]) begin
        aper_hi[APER_SEL_BIT] <= cfg_wdata_i[APER_SEL_BIT];
      end
    end
  end

  // Register window base, 13 bits over two byte lanes
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      win_hi <= WINDOW_RST[31:WIN_BASE_LSB];
    end else if (wr_take && dword == DW_WINDOW) begin
      if (cfg_be_i[3]) begin
        win_hi[31:24] <= cfg_wdata_i[31:24];
      end
      if (cfg_be_i[2]) begin
        win_hi[23:WIN_BASE_LSB] <= cfg_wdata_i[23:WIN_BASE_LSB];
      end
    end
  end

  // Interrupt line is stored for software and mirrored on irq_routing_line_o
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      irq_routing_line <= IRQ_LINE_RST;
    end else if (wr_take && dword == DW_IRQ && cfg_be_i[0]) begin
      irq_routing_line <= cfg_wdata_i[7:0];
    end
  end

  // Subsystem vendor id in low half, subsystem id in high half
  for (genvar i = 0; i < SUBSYS_COUNT; i++) begin : g_subsys
    gpch_wonce_if wonce ();

    assign wonce.wr    = wr_take && dword == DW_SUBSYS && |cfg_be_i[2*i +: 2];
    assign wonce.be    = cfg_be_i[2*i +: 2];
    assign wonce.wdata = cfg_wdata_i[16*i +: 16];
    assign subsys_value[i] = wonce.value;
    assign subsys_lock[i]  = wonce.locked;

    gpch_write_once u_ident (
      .clock_i (clock_i),
      .nrst_i  (nrst_i),
      .port    (wonce.store)
    );
  end

  // Hardwired low bits fill out the base registers
  always_comb begin
    aperture_word = APERTURE_RST;
    aperture_word[31:APER_SEL_BIT] = aper_hi;
    // Mask bit 25 at once; the stored copy only clears a cycle later
    aperture_word[APER_SEL_BIT] = aper_hi[APER_SEL_BIT] && size_select_i;
    window_word = WINDOW_RST;
    window_word[31:WIN_BASE_LSB] = win_hi;
  end

  // Read mux; unmapped dwords and bytes below 0eh read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (dword)
      DW_HEADER: begin
        next_rdata[23:16] = HEADER_LAYOUT_VAL;
        next_rdata[31:24] = SELF_TEST_VAL;
      end
      DW_APERTURE: begin
        next_rdata = aperture_word;
      end
      DW_WINDOW: begin
        next_rdata = window_word;
      end
      DW_SUBSYS: begin
        next_rdata = {subsys_value[1], subsys_value[0]};
      end
      DW_ROM: begin
        next_rdata = OPTION_ROM_VAL;
      end
      DW_CAP: begin
        next_rdata[7:0] = CAP_POINTER_VAL;
      end
      DW_IRQ: begin
        next_rdata = {MAX_LATENCY_VAL, MIN_GRANT_VAL, IRQ_PIN_VAL,
                      irq_routing_line};
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // Every request is answered, write or read, mapped or not
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      cfg_ack_o <= 1'b0;
    end else begin
      cfg_ack_o <= cfg_req_i;
    end
  end

  // Read data holds until the next read is taken
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      cfg_rdata_o <= 32'h0000_0000;
    end else if (rd_take) begin
      cfg_rdata_o <= next_rdata;
    end
  end

  // Mirrors of programmed state for the rest of the function
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      aperture_base_o    <= APERTURE_RST;
      aperture_64mb_o    <= 1'b1;
      window_base_o      <= WINDOW_RST;
      irq_routing_line_o <= IRQ_LINE_RST;
      subsys_locked_o    <= 2'b00;
    end else begin
      aperture_base_o    <= aperture_word;
      aperture_64mb_o    <= !size_select_i;
      window_base_o      <= window_word;
      irq_routing_line_o <= irq_routing_line;
      subsys_locked_o    <= {subsys_lock[1], subsys_lock[0]};
    end
  end

  // Address decode against the assigned ranges, one cycle late
  // A 32 MB aperture compares bit 25 as well, 64 MB ignores it
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      aperture_hit_o <= 1'b0;
      window_hit_o   <= 1'b0;
    end else begin
      if (size_select_i) begin
        aperture_hit_o <= mem_addr_i[31:APER_SEL_BIT] == aper_hi;
      end else begin
        aperture_hit_o <= mem_addr_i[31:APER_BASE_LSB] == aper_hi[31:APER_BASE_LSB];
      end
      window_hit_o <= mem_addr_i[31:WIN_BASE_LSB] == win_hi;
    end
  end

endmodule

// >>> bench/gpch_config_header_assertions.sv
// Purpose: Port checks of the config header
// Assumes: One clock, synchronous reset
// Notes:   Read data checked the cycle after a read is taken
`timescale 1ns/1ps
module gpch_chk
  import gpch_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        nrst_i,
  input wire logic        size_select_i,
  input wire logic        cfg_req_i,
  input wire logic        cfg_wr_i,
  input wire logic [7:0]  cfg_addr_i,
  input wire logic [3:0]  cfg_be_i,
  input wire logic        cfg_ack_o,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic [31:0] aperture_base_o,
  input wire logic        aperture_64mb_o,
  input wire logic [31:0] window_base_o,
  input wire logic [7:0]  irq_routing_line_o,
  input wire logic [1:0]  subsys_locked_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  sequence s_acc(w, dw);
    cfg_req_i && cfg_wr_i == w && cfg_addr_i[7:2] == dw;
  endsequence
  property p_ack;
    cfg_req_i |=> cfg_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_hdr;
    s_acc(1'b0, DW_HEADER) |=> cfg_rdata_o == 32'h0;
  endproperty
  a_hdr: assert property (p_hdr) else $error("header dword");
  property p_aper;
    s_acc(1'b0, DW_APERTURE) |=> cfg_rdata_o[24:0] == 25'h8;
  endproperty
  a_aper: assert property (p_aper) else $error("aperture low bits");
  property p_sel;
    (!size_select_i) [*2] |=> !aperture_base_o[25] && aperture_64mb_o;
  endproperty
  a_sel: assert property (p_sel) else $error("64 MB mode bit");
  property p_win;
    s_acc(1'b0, DW_WINDOW) |=> cfg_rdata_o == {window_base_o[31:19], 19'h0};
  endproperty
  a_win: assert property (p_win) else $error("window dword");
  property p_cap;
    s_acc(1'b0, DW_CAP) |=> cfg_rdata_o == 32'hdc;
  endproperty
  a_cap: assert property (p_cap) else $error("cap pointer");
  property p_irq;
    s_acc(1'b0, DW_IRQ) |=> cfg_rdata_o == {16'h0, 8'h01, irq_routing_line_o};
  endproperty
  a_irq: assert property (p_irq) else $error("irq dword");
  property p_lock;
    s_acc(1'b1, DW_SUBSYS) ##0 cfg_be_i[0] |-> ##2 subsys_locked_o[0] [*3];
  endproperty
  a_lock: assert property (p_lock) else $error("vendor id lock");
endmodule

bind gpch_config_header gpch_chk i_chk (
  .clock_i(clock_i), .nrst_i(nrst_i), .size_select_i(size_select_i),
  .cfg_req_i(cfg_req_i), .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i),
  .cfg_be_i(cfg_be_i), .cfg_ack_o(cfg_ack_o), .cfg_rdata_o(cfg_rdata_o),
  .aperture_base_o(aperture_base_o), .aperture_64mb_o(aperture_64mb_o),
  .window_base_o(window_base_o), .irq_routing_line_o(irq_routing_line_o),
  .subsys_locked_o(subsys_locked_o)
);

// >>> bench/gpch_config_header_bench.sv
// Purpose: Self-checking bench of the config header
// Assumes: One access at a time, ack one cycle later
// Notes:   Expected values come from the register table
`timescale 1ns/1ps
module gpch_config_header_bench;
  import gpch_pkg::*;
  logic        clock_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        size_select_i = 1'b0;
  logic        cfg_req_i = 1'b0;
  logic        cfg_wr_i = 1'b0;
  logic [7:0]  cfg_addr_i = 8'h00;
  logic [3:0]  cfg_be_i = 4'h0;
  logic [31:0] cfg_wdata_i = 32'h0;
  logic [31:0] mem_addr_i = 32'h0;
  logic        cfg_ack_o, aperture_64mb_o, aperture_hit_o, window_hit_o;
  logic [31:0] cfg_rdata_o, aperture_base_o, window_base_o, rd;
  logic [7:0]  irq_routing_line_o;
  logic [1:0]  subsys_locked_o;
  int          num_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;

  always #2.5 clock_i = ~clock_i;

  gpch_config_header i_dut (
    .clock_i(clock_i), .nrst_i(nrst_i), .size_select_i(size_select_i),
    .cfg_req_i(cfg_req_i), .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i),
    .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i), .mem_addr_i(mem_addr_i),
    .cfg_ack_o(cfg_ack_o), .cfg_rdata_o(cfg_rdata_o),
    .aperture_base_o(aperture_base_o), .aperture_64mb_o(aperture_64mb_o),
    .window_base_o(window_base_o), .irq_routing_line_o(irq_routing_line_o),
    .subsys_locked_o(subsys_locked_o), .aperture_hit_o(aperture_hit_o),
    .window_hit_o(window_hit_o)
  );

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Ack and read data are sampled the edge after the taking edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] d);
    @(posedge clock_i);
    cfg_req_i <= 1'b1;
    cfg_wr_i <= w;
    cfg_addr_i <= a;
    cfg_be_i <= be;
    cfg_wdata_i <= d;
    @(posedge clock_i);
    cfg_req_i <= 1'b0;
    @(posedge clock_i);
    chk("ack", 32'h1, {31'h0, cfg_ack_o});
    rd = cfg_rdata_o;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 4'h0, 32'h0);
    chk(nm, exp, rd);
  endtask

  task automatic rst();
    nrst_i <= 1'b0;
    repeat (12) @(posedge clock_i);
    nrst_i <= 1'b1;
  endtask

  task automatic t_readonly();
    logic [7:0]  ad[4] = '{8'h0c, 8'h30, 8'h34, 8'h3c};
    logic [31:0] ex[4] = '{32'h0, 32'h0, 32'hdc, 32'h100};
    for (int i = 0; i < 4; i++) acc(1'b1, ad[i], 4'he, 32'hffff_ffff);
    for (int i = 0; i < 4; i++) rdchk("ro dword", ad[i], ex[i]);
  endtask

  task automatic t_aperture();
    acc(1'b1, 8'h10, 4'hf, 32'hffff_ffff);
    rdchk("aper 64", 8'h10, 32'hfc00_0008);
    size_select_i <= 1'b1;
    acc(1'b1, 8'h10, 4'hf, 32'hffff_ffff);
    rdchk("aper 32", 8'h10, 32'hfe00_0008);
    chk("aper mirror", 32'hfe00_0008, aperture_base_o);
    chk("64mb flag", 32'h0, {31'h0, aperture_64mb_o});
    size_select_i <= 1'b0;
    rdchk("aper back", 8'h10, 32'hfc00_0008);
    mem_addr_i <= 32'hfe00_0000;
    repeat (2) @(posedge clock_i);
    chk("aper hit 64", 32'h1, {31'h0, aperture_hit_o});
    size_select_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    chk("aper hit 32", 32'h0, {31'h0, aperture_hit_o});
    size_select_i <= 1'b0;
  endtask

  task automatic t_window();
    mem_addr_i <= 32'hfff8_1234;
    acc(1'b1, 8'h14, 4'hf, 32'hffff_ffff);
    rdchk("window", 8'h14, 32'hfff8_0000);
    chk("window hit", 32'h1, {31'h0, window_hit_o});
    chk("window mirror", 32'hfff8_0000, window_base_o);
    mem_addr_i <= 32'h0007_ffff;
    repeat (2) @(posedge clock_i);
    chk("window miss", 32'h0, {31'h0, window_hit_o});
  endtask

  task automatic t_once();
    acc(1'b1, 8'h2c, 4'h3, 32'h0000_1234);
    acc(1'b1, 8'h2c, 4'h3, 32'h0000_5678);
    acc(1'b1, 8'h2c, 4'hc, 32'habcd_0000);
    acc(1'b1, 8'h2c, 4'hc, 32'h9999_0000);
    rdchk("ids", 8'h2c, 32'habcd_1234);
    chk("locks", 32'h3, {30'h0, subsys_locked_o});
    rst();
    rdchk("ids reset", 8'h2c, 32'h0);
    chk("locks reset", 32'h0, {30'h0, subsys_locked_o});
    acc(1'b1, 8'h2c, 4'h1, 32'h0000_0042);
    acc(1'b1, 8'h2c, 4'h2, 32'h0000_7700);
    rdchk("ids reopen", 8'h2c, 32'h0000_0042);
  endtask

  task automatic t_irq();
    acc(1'b1, 8'h3c, 4'h1, 32'h0000_005a);
    rdchk("irq", 8'h3c, 32'h0000_015a);
    chk("irq line", 32'h5a, {24'h0, irq_routing_line_o});
  endtask

  task automatic end_sim();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Whole run is a little over a hundred cycles
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      end_sim();
    end
  end

  initial begin
    rst();
    rdchk("hdr", 8'h0c, 32'h0);
    rdchk("aper rst", 8'h10, 32'h8);
    rdchk("rom", 8'h30, 32'h0);
    rdchk("cap", 8'h34, 32'hdc);
    rdchk("irq rst", 8'h3c, 32'h100);
    t_readonly();
    t_aperture();
    t_window();
    t_once();
    t_irq();
    end_sim();
  end
endmodule
